// *** testbench/reset_source_flags_tb_top.sv ***
// Purpose: self-checking bench for the reset-source flag block
// Assumes: SRESET_CYCLES shortened to 2 so software resets come quickly
// Notes:   registers over AXI4-Lite tasks, events driven straight onto the port
`timescale 1ns/100ps
module reset_source_flags_tb_top;
  localparam int LIMIT = 20000;
  localparam logic [7:0] CODES [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};

  logic                               core_clk;
  logic                               reset_n;
  reset_source_pkg::axi_req_type      axi_req;
  reset_source_pkg::axi_rsp_type      axi_rsp;
  reset_source_pkg::event_in_type     events;
  logic                               device_reset;
  reset_source_pkg::reset_action_type reset_action;
  logic [7:0]                         threshold_value;
  logic                               irq;
  int                                 errors = 0;
  int                                 n_compared = 0;
  int                                 cycles = 0;
  int                                 n_rst = 0;
  int                                 base;
  logic [31:0]                        rd;
  logic [1:0]                         rsp;

  reset_source_flags #(.SRESET_CYCLES(2)) dut_u (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .axi_req         (axi_req),
    .axi_rsp         (axi_rsp),
    .events          (events),
    .device_reset    (device_reset),
    .reset_action    (reset_action),
    .threshold_value (threshold_value),
    .irq             (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // counts device reset pulses and cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (device_reset === 1'b1) n_rst++;
    if (cycles == LIMIT) begin
      errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'h1;
    axi_req.bready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (axi_req.awvalid && axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) begin
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (axi_req.arvalid && axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) begin
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    cmp_val({30'h0, r}, {30'h0, reset_source_pkg::RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    cmp_val(d, exp);
    cmp_val({30'h0, r}, {30'h0, reset_source_pkg::RESP_OKAY});
  endtask

  // one-cycle event pulse; low_power is left at lp afterwards
  task automatic ev_pulse(input logic lvr, input logic wdt, input logic pin,
                          input logic wci, input logic lp);
    @(posedge core_clk);
    events <= {lvr, wdt, pin, wci, lp};
    @(posedge core_clk);
    events <= {4'h0, lp};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    axi_req = '0;
    events  = '0;
    tick(12);
    cmp_val({26'h0, reset_action}, {26'h0, reset_source_pkg::ACT_POR});
    reset_n <= 1'b1;
    tick(2);
    cmp_val({26'h0, reset_action}, 32'h0);
    cmp_val({24'h0, threshold_value}, 32'h66);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h0);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h0);
    rd_chk(reset_source_pkg::OFS_IRQ_EN, 32'h0);
    rd_chk(reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG, 32'h66);
    rd_chk(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG, 32'h55);
    axi_read(8'h20, rd, rsp);
    cmp_val(rd, 32'h0);
    cmp_val({30'h0, rsp}, {30'h0, reset_source_pkg::RESP_SLVERR});
    axi_write(8'h02, 32'hff, rsp);
    cmp_val({30'h0, rsp}, {30'h0, reset_source_pkg::RESP_SLVERR});
    // low-voltage reset counts only outside idle/sleep
    base = n_rst;
    ev_pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    ev_pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmp_val(n_rst - base, 0);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h0);
    ev_pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    tick(2);
    cmp_val(n_rst - base, 1);
    wr_ok(reset_source_pkg::OFS_FLAGS, 32'hff);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h4);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h0);
    // watchdog-control event lands on the edge that commits the clear of bit 0
    fork
      wr_ok(reset_source_pkg::OFS_FLAGS, 32'hfe);
      begin
        tick(1);
        ev_pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      end
    join
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h5);
    wr_ok(reset_source_pkg::OFS_FLAGS, 32'hfa);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h0);
    // every legal threshold code is kept with no reset
    foreach (CODES[i]) begin
      base = n_rst;
      wr_ok(reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG, {24'h0, CODES[i]});
      tick(4);
      rd_chk(reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG, {24'h0, CODES[i]});
      cmp_val(n_rst - base, 0);
    end
    base = n_rst;
    wr_ok(reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG, 32'h12);
    tick(6);
    cmp_val(n_rst - base, 1);
    cmp_val({24'h0, threshold_value}, 32'h66);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h2);
    wr_ok(reset_source_pkg::OFS_FLAGS, 32'hfd);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h0);
    // reset control register: legal pin code, then an illegal one
    base = n_rst;
    wr_ok(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG, 32'haa);
    rd_chk(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG, 32'haa);
    wr_ok(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG, 32'h12);
    tick(6);
    cmp_val(n_rst - base, 1);
    rd_chk(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG, 32'h55);
    ev_pulse(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h9);
    wr_ok(reset_source_pkg::OFS_FLAGS, 32'hf0);
    rd_chk(reset_source_pkg::OFS_FLAGS, 32'h0);
    base = n_rst;
    wr_ok(reset_source_pkg::OFS_FC1, 32'h54);
    tick(3);
    cmp_val(n_rst - base, 0);
    wr_ok(reset_source_pkg::OFS_FC1, 32'h55);
    tick(3);
    cmp_val(n_rst - base, 1);
    // watchdog timeouts in normal and in sleep mode, pin reset between
    ev_pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk);
    cmp_val({26'h0, reset_action}, 32'h0);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h20);
    ev_pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h20);
    wr_ok(reset_source_pkg::OFS_IRQ_CLEAR, 32'h3f);
    rd_chk(reset_source_pkg::OFS_IRQ_STAT, 32'h0);
    wr_ok(reset_source_pkg::OFS_IRQ_EN, 32'h10);
    ev_pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge core_clk);
    cmp_val({26'h0, reset_action}, {26'h0, reset_source_pkg::ACT_WDT_SLEEP});
    @(posedge core_clk);
    cmp_val({26'h0, reset_action}, 32'h0);
    cmp_val({31'h0, irq}, 32'h1);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h30);
    wr_ok(reset_source_pkg::OFS_STATUS, 32'h0);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h30);
    ev_pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // interrupt masked, unmasked, then cleared
    rd_chk(reset_source_pkg::OFS_IRQ_STAT, 32'h10);
    rd_chk(reset_source_pkg::OFS_IRQ_CLEAR, 32'h0);
    wr_ok(reset_source_pkg::OFS_IRQ_EN, 32'h0);
    tick(2);
    cmp_val({31'h0, irq}, 32'h0);
    wr_ok(reset_source_pkg::OFS_IRQ_EN, 32'h10);
    tick(2);
    cmp_val({31'h0, irq}, 32'h1);
    wr_ok(reset_source_pkg::OFS_IRQ_CLEAR, 32'h10);
    tick(2);
    cmp_val({31'h0, irq}, 32'h0);
    rd_chk(reset_source_pkg::OFS_IRQ_STAT, 32'h0);
    // second power-on reset in mid-run
    @(posedge core_clk);
    reset_n <= 1'b0;
    tick(3);
    cmp_val({26'h0, reset_action}, {26'h0, reset_source_pkg::ACT_POR});
    reset_n <= 1'b1;
    tick(2);
    rd_chk(reset_source_pkg::OFS_STATUS, 32'h0);
    rd_chk(reset_source_pkg::OFS_IRQ_EN, 32'h0);
    cmp_val({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule // reset_source_flags_tb_top

// *** verilog/reset_source_flags.sv ***
// Purpose: reset-cause flags, status timeout/power-down flags, reset requests
// Assumes: event inputs synchronous to core_clk, one-cycle pulses except
//          lvr_detect (already qualified for its minimum time) and low_power
// Notes:   reset_n is the power-on reset; device_reset is a request pulse
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module reset_source_flags #(
  parameter int SRESET_CYCLES = reset_source_pkg::SRESET_CYCLES
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset_n,
  input  wire reset_source_pkg::axi_req_type     axi_req,
  output reset_source_pkg::axi_rsp_type          axi_rsp,
  input  wire reset_source_pkg::event_in_type    events,
  output logic                                   device_reset,
  output reset_source_pkg::reset_action_type     reset_action,
  output logic [7:0]                             threshold_value,
  output logic                                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  reset_source_pkg::axi_rsp_type rsp_q, rsp_d;
  logic                                   aw_full_q, aw_full_d;
  logic                                   w_full_q, w_full_d;
  logic [reset_source_pkg::ADDR_W-1:0]    awaddr_q, awaddr_d;
  logic [reset_source_pkg::DATA_W-1:0]    wdata_q, wdata_d;
  logic [3:0]                             wstrb_q, wstrb_d;
  logic                                   wr_fire;

  // register state
  logic [3:0]                              flags_q, flags_d;
  logic                                    to_q, to_d;
  logic                                    pdf_q, pdf_d;
  logic [7:0]                              low_voltage_threshold_reg_q, low_voltage_threshold_reg_d;
  logic [7:0]                              reset_pin_control_reg_q, reset_pin_control_reg_d;
  logic [7:0]                              fc1_q, fc1_d;
  logic [reset_source_pkg::IRQ_W-1:0]      irq_st_q, irq_st_d;
  logic [reset_source_pkg::IRQ_W-1:0]      irq_en_q, irq_en_d;
  logic [reset_source_pkg::IRQ_W-1:0]      irq_set;
  logic                                    dev_rst_q, dev_rst_d;
  logic                                    irq_q, irq_d;
  reset_source_pkg::reset_action_type      act_q, act_d;

  logic lvr_ok;
  logic flash_hit;
  logic low_voltage_threshold_reg_fire;
  logic reset_pin_control_reg_fire;
  logic low_voltage_threshold_reg_bad;
  logic reset_pin_control_reg_bad;

  function automatic logic mapped(input logic [reset_source_pkg::ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= reset_source_pkg::OFS_IRQ_EN);
  endfunction

  function automatic logic wr_hit(input logic [reset_source_pkg::ADDR_W-1:0] ofs);
    return wr_fire && (awaddr_q == ofs) && wstrb_q[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  assign wr_fire = aw_full_q && w_full_q && !rsp_q.bvalid;

  always_comb begin
    rsp_d     = rsp_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    if (axi_req.awvalid && rsp_q.awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp_q.wready) begin
      w_full_d = 1'b1;
      wdata_d  = axi_req.wdata;
      wstrb_d  = axi_req.wstrb;
    end
    if (rsp_q.bvalid && axi_req.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      aw_full_d     = 1'b0;
      w_full_d      = 1'b0;
      rsp_d.bvalid  = 1'b1;
      rsp_d.bresp   = mapped(awaddr_q) ? reset_source_pkg::RESP_OKAY
                                       : reset_source_pkg::RESP_SLVERR;
    end
    rsp_d.awready = !aw_full_d;
    rsp_d.wready  = !w_full_d;
    if (rsp_q.rvalid && axi_req.rready) begin
      rsp_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rresp  = mapped(axi_req.araddr) ? reset_source_pkg::RESP_OKAY
                                            : reset_source_pkg::RESP_SLVERR;
      rsp_d.rdata  = '0;
      unique case (axi_req.araddr)
        reset_source_pkg::OFS_FLAGS:    rsp_d.rdata[3:0] = flags_q; // upper bits zero
        reset_source_pkg::OFS_STATUS: begin
          rsp_d.rdata[reset_source_pkg::STAT_TO]  = to_q;
          rsp_d.rdata[reset_source_pkg::STAT_PDF] = pdf_q;
        end
        reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG:     rsp_d.rdata[7:0] = low_voltage_threshold_reg_q;
        reset_source_pkg::OFS_RESET_PIN_CONTROL_REG:     rsp_d.rdata[7:0] = reset_pin_control_reg_q;
        reset_source_pkg::OFS_FC1:      rsp_d.rdata[7:0] = fc1_q;
        reset_source_pkg::OFS_IRQ_STAT: rsp_d.rdata[reset_source_pkg::IRQ_W-1:0] = irq_st_q;
        reset_source_pkg::OFS_IRQ_EN:   rsp_d.rdata[reset_source_pkg::IRQ_W-1:0] = irq_en_q;
        default:                        rsp_d.rdata = '0;
      endcase
    end
    rsp_d.arready = !rsp_d.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rsp_q     <= '0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      rsp_q     <= rsp_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delayed software resets from illegal control values
  assign low_voltage_threshold_reg_bad = !reset_source_pkg::is_lvr_level(low_voltage_threshold_reg_q) &&
                    (low_voltage_threshold_reg_q != reset_source_pkg::LOW_VOLTAGE_THRESHOLD_REG_OFF);
  assign reset_pin_control_reg_bad = (reset_pin_control_reg_q != reset_source_pkg::RESET_PIN_CONTROL_REG_POR) &&
                    (reset_pin_control_reg_q != reset_source_pkg::RESET_PIN_CONTROL_REG_PIN);

  soft_reset_delay #(.CYCLES(SRESET_CYCLES)) low_voltage_threshold_reg_delay (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .arm      (low_voltage_threshold_reg_bad),
    .fire     (low_voltage_threshold_reg_fire)
  );

  soft_reset_delay #(.CYCLES(SRESET_CYCLES)) reset_pin_control_reg_delay (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .arm      (reset_pin_control_reg_bad),
    .fire     (reset_pin_control_reg_fire)
  );

  // low-voltage reset is off when disabled by code or in idle/sleep
  assign lvr_ok    = events.lvr_detect && !events.low_power &&
                     reset_source_pkg::is_lvr_level(low_voltage_threshold_reg_q);
  // written out in full: a continuous assign does not follow what a function reads
  assign flash_hit = wr_fire && (awaddr_q == reset_source_pkg::OFS_FC1) && wstrb_q[0] &&
                     (wdata_q[7:0] == reset_source_pkg::FC1_TRIG);

  ////////////////////////////////////////////////////////////////////////////
  // flags, control registers and reset requests
  always_comb begin
    flags_d = flags_q;
    if (wr_hit(reset_source_pkg::OFS_FLAGS)) begin
      flags_d = flags_q & wdata_q[3:0];     // writing zero clears only
    end
    if (events.wdt_ctrl_invalid) flags_d[reset_source_pkg::FLAG_WRF] = 1'b1;
    if (lvr_ok)    flags_d[reset_source_pkg::FLAG_LOW_VOLTAGE_RESET_FLAG] = 1'b1;
    if (low_voltage_threshold_reg_fire) flags_d[reset_source_pkg::FLAG_LRF]  = 1'b1;
    if (reset_pin_control_reg_fire) flags_d[reset_source_pkg::FLAG_CTRL_REG_SOFT_RESET_FLAG] = 1'b1;

    // pin and low-voltage resets leave both untouched
    to_d  = to_q;
    pdf_d = pdf_q;
    act_d = reset_source_pkg::ACT_NONE;
    if (events.wdt_timeout) begin
      to_d = 1'b1;
      if (events.low_power) begin
        pdf_d = 1'b1;
        act_d = reset_source_pkg::ACT_WDT_SLEEP;
      end
    end

    low_voltage_threshold_reg_d = low_voltage_threshold_reg_q;
    if (wr_hit(reset_source_pkg::OFS_LOW_VOLTAGE_THRESHOLD_REG)) low_voltage_threshold_reg_d = wdata_q[7:0];
    if (low_voltage_threshold_reg_fire) low_voltage_threshold_reg_d = reset_source_pkg::LOW_VOLTAGE_THRESHOLD_REG_POR;

    fc1_d = fc1_q;
    if (wr_hit(reset_source_pkg::OFS_FC1)) fc1_d = wdata_q[7:0];

    dev_rst_d = flash_hit || lvr_ok || low_voltage_threshold_reg_fire || reset_pin_control_reg_fire;

    reset_pin_control_reg_d = reset_pin_control_reg_q;
    if (wr_hit(reset_source_pkg::OFS_RESET_PIN_CONTROL_REG)) reset_pin_control_reg_d = wdata_q[7:0];
    if (dev_rst_d || events.pin_reset) reset_pin_control_reg_d = reset_source_pkg::RESET_PIN_CONTROL_REG_POR;

    irq_set = '0;
    irq_set[reset_source_pkg::IRQ_WRF]   = events.wdt_ctrl_invalid;
    irq_set[reset_source_pkg::IRQ_LRF]   = low_voltage_threshold_reg_fire;
    irq_set[reset_source_pkg::IRQ_LOW_VOLTAGE_RESET_FLAG]  = lvr_ok;
    irq_set[reset_source_pkg::IRQ_CTRL_REG_SOFT_RESET_FLAG]  = reset_pin_control_reg_fire;
    irq_set[reset_source_pkg::IRQ_TO]    = events.wdt_timeout;
    irq_set[reset_source_pkg::IRQ_FLASH] = flash_hit;
    irq_st_d = irq_st_q;
    if (wr_hit(reset_source_pkg::OFS_IRQ_CLEAR)) begin
      irq_st_d = irq_st_q & ~wdata_q[reset_source_pkg::IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | irq_set;
    irq_en_d = irq_en_q;
    if (wr_hit(reset_source_pkg::OFS_IRQ_EN)) begin
      irq_en_d = wdata_q[reset_source_pkg::IRQ_W-1:0];
    end
    irq_d = |(irq_st_d & irq_en_d);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flags_q   <= reset_source_pkg::FLAGS_POR;
      to_q      <= 1'b0;
      pdf_q     <= 1'b0;
      low_voltage_threshold_reg_q    <= reset_source_pkg::LOW_VOLTAGE_THRESHOLD_REG_POR;
      reset_pin_control_reg_q    <= reset_source_pkg::RESET_PIN_CONTROL_REG_POR;
      fc1_q     <= reset_source_pkg::FC1_POR;
      irq_st_q  <= '0;
      irq_en_q  <= '0;
      irq_q     <= 1'b0;
      dev_rst_q <= 1'b0;
      act_q     <= reset_source_pkg::ACT_POR;
    end else begin
      flags_q   <= flags_d;
      to_q      <= to_d;
      pdf_q     <= pdf_d;
      low_voltage_threshold_reg_q    <= low_voltage_threshold_reg_d;
      reset_pin_control_reg_q    <= reset_pin_control_reg_d;
      fc1_q     <= fc1_d;
      irq_st_q  <= irq_st_d;
      irq_en_q  <= irq_en_d;
      irq_q     <= irq_d;
      dev_rst_q <= dev_rst_d;
      act_q     <= act_d;
    end
  end

  assign axi_rsp         = rsp_q;
  assign device_reset    = dev_rst_q;
  assign reset_action    = act_q;
  assign threshold_value = low_voltage_threshold_reg_q;
  assign irq             = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_flags_upper_zero: assert property (
    (axi_req.arvalid && rsp_q.arready && axi_req.araddr == reset_source_pkg::OFS_FLAGS)
    |=> rsp_q.rvalid && rsp_q.rdata[31:4] == 28'h0000000)
    else $error("flag register upper bits not zero");

  a_lvr_flag_set: assert property (
    lvr_ok |=> flags_q[reset_source_pkg::FLAG_LOW_VOLTAGE_RESET_FLAG] && dev_rst_q)
    else $error("low-voltage flag or reset missing");

  a_lrf_restore: assert property (
    low_voltage_threshold_reg_fire |=> flags_q[reset_source_pkg::FLAG_LRF] && dev_rst_q
                  && low_voltage_threshold_reg_q == reset_source_pkg::LOW_VOLTAGE_THRESHOLD_REG_POR)
    else $error("illegal threshold not reset and flagged");

  a_flash_reset: assert property (
    (wr_fire && awaddr_q == reset_source_pkg::OFS_FC1 && wstrb_q[0]
     && wdata_q[7:0] == reset_source_pkg::FC1_TRIG) |=> dev_rst_q)
    else $error("flash trigger did not reset device");

  a_timeout_fast: assert property (
    (events.wdt_timeout && !events.low_power) |=> to_q && $stable(pdf_q))
    else $error("fast-mode timeout flags wrong");

  a_timeout_sleep: assert property (
    (events.wdt_timeout && events.low_power)
    |=> to_q && pdf_q && act_q.pc_clear && act_q.sp_top && !act_q.timers_off)
    else $error("sleep timeout state wrong");

  a_pin_keeps: assert property (
    (events.pin_reset && !events.wdt_timeout) |=> $stable(to_q) && $stable(pdf_q))
    else $error("pin reset changed status flags");

  a_por_state: assert property (@(posedge core_clk) disable iff (1'b0)
    !reset_n |=> !to_q && !pdf_q && act_q == reset_source_pkg::ACT_POR && irq_en_q == '0)
    else $error("power-on state wrong");

  a_ctrl_reg_soft_reset_flag_set: assert property (
    reset_pin_control_reg_fire |=> flags_q[reset_source_pkg::FLAG_CTRL_REG_SOFT_RESET_FLAG] && reset_pin_control_reg_q == reset_source_pkg::RESET_PIN_CONTROL_REG_POR)
    else $error("reset control flag not set");

  c_low_voltage_threshold_reg_fire: cover property (low_voltage_threshold_reg_fire);
  c_flash_reset: cover property (flash_hit);
  c_sleep_timeout: cover property (events.wdt_timeout && events.low_power);
  c_irq_raised: cover property ($rose(irq_q));

endmodule // reset_source_flags

// *** verilog/reset_source_pkg.sv ***
// Purpose: constants and carriers shared by the reset-source flag block
// Assumes: 50 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes:   registers are 8 bits or narrower and sit in byte lane 0
package reset_source_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W  = 6;

  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOW_VOLTAGE_THRESHOLD_REG      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESET_PIN_CONTROL_REG      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FC1       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h1c;

  localparam int FLAG_WRF  = 0;
  localparam int FLAG_LRF  = 1;
  localparam int FLAG_LOW_VOLTAGE_RESET_FLAG = 2;
  localparam int FLAG_CTRL_REG_SOFT_RESET_FLAG = 3;
  localparam int STAT_PDF  = 4;
  localparam int STAT_TO   = 5;

  localparam int IRQ_WRF   = 0;
  localparam int IRQ_LRF   = 1;
  localparam int IRQ_LOW_VOLTAGE_RESET_FLAG  = 2;
  localparam int IRQ_CTRL_REG_SOFT_RESET_FLAG  = 3;
  localparam int IRQ_TO    = 4;
  localparam int IRQ_FLASH = 5;

  localparam logic [3:0] FLAGS_POR = 4'h0;
  localparam logic [7:0] LOW_VOLTAGE_THRESHOLD_REG_POR  = 8'h66;
  localparam logic [7:0] LOW_VOLTAGE_THRESHOLD_REG_OFF  = 8'hf0;
  localparam logic [7:0] LV_1V7    = 8'h66;
  localparam logic [7:0] LV_1V9    = 8'h55;
  localparam logic [7:0] LV_2V55   = 8'h33;
  localparam logic [7:0] LV_3V15   = 8'h99;
  localparam logic [7:0] LV_3V8    = 8'haa;
  localparam logic [7:0] RESET_PIN_CONTROL_REG_POR  = 8'h55;
  localparam logic [7:0] RESET_PIN_CONTROL_REG_PIN  = 8'haa;
  localparam logic [7:0] FC1_TRIG  = 8'h55;
  localparam logic [7:0] FC1_POR   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ        = 50;
  localparam int T_SRESET_NS    = 1000;
  localparam int SRESET_CYCLES  = (T_SRESET_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic lvr_detect;
    logic wdt_timeout;
    logic pin_reset;
    logic wdt_ctrl_invalid;
    logic low_power;
  } event_in_type;

  typedef struct packed {
    logic pc_clear;
    logic sp_top;
    logic int_disable;
    logic wdt_tb_clear;
    logic timers_off;
    logic ports_input;
  } reset_action_type;

  localparam reset_action_type ACT_NONE = 6'h00;
  localparam reset_action_type ACT_POR  = 6'h3f;
  localparam reset_action_type ACT_WDT_SLEEP = 6'h30;

  function automatic logic is_lvr_level(input logic [7:0] v);
    return (v == LV_1V7) || (v == LV_1V9) || (v == LV_2V55) ||
           (v == LV_3V15) || (v == LV_3V8);
  endfunction

endpackage

// *** verilog/soft_reset_delay.sv ***
// Purpose: delays a software reset request by a fixed count of cycles
// Assumes: arm stays high while the offending register value is present
// Notes:   a corrected value before the count ends cancels the reset
`timescale 1ns/100ps
module soft_reset_delay #(
  parameter int CYCLES = reset_source_pkg::SRESET_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic arm,
  output logic      fire
);

  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             fire_q;
  logic             fire_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    count_d = '0;
    fire_d  = 1'b0;
    if (arm && !fire_q) begin
      if (count_q == LAST) begin
        fire_d = 1'b1;
      end else begin
        count_d = count_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_q <= '0;
      fire_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      fire_q  <= fire_d;
    end
  end

  assign fire = fire_q;

endmodule // soft_reset_delay
